// [hw/mac_defs.vh]
// Constants for the circular-buffer address correction block
`ifndef MAC_DEFS_VH
`define MAC_DEFS_VH
// Address width and working-register count
`define MAC_AW 16
`define MAC_NREG 16
`define MAC_SELW 4
// Addressing modes of an access
`define MAC_MODE_PLAIN 2'h0
`define MAC_MODE_PRE 2'h1
`define MAC_MODE_POST 2'h2
`define MAC_MODE_OFFS 2'h3
// Reset value of the pointer and address outputs
`define MAC_ADDR_RST 16'h0000
`endif

// [hw/mac_top.v]
// Circular-buffer address correction for the primary and secondary address generators
`timescale 1ns/10ps
`default_nettype none
`include "mac_defs.vh"
module mac_top #(
   parameter AW = `MAC_AW,
   parameter SELW = `MAC_SELW
) (
   input wire i_core_clk,
   input wire i_nrst,
   // Circular buffer configuration, one pair per address space
   input wire [AW-1:0] i_pri_start,
   input wire [AW-1:0] i_pri_end,
   input wire [AW-1:0] i_sec_start,
   input wire [AW-1:0] i_sec_end,
   input wire i_pri_circ_en,
   input wire i_sec_circ_en,
   input wire i_pri_bitrev_en,
   input wire i_pri_decrement,
   input wire i_sec_decrement,
   // Primary read address generator request
   input wire i_prd_valid,
   input wire [AW-1:0] i_prd_addr,
   input wire [1:0] i_prd_mode,
   input wire [SELW-1:0] i_prd_reg,
   // Primary write address generator request
   input wire i_pwr_valid,
   input wire [AW-1:0] i_pwr_addr,
   input wire [1:0] i_pwr_mode,
   input wire [SELW-1:0] i_pwr_reg,
   // Secondary address generator request
   input wire i_sec_valid,
   input wire [AW-1:0] i_sec_addr,
   input wire [1:0] i_sec_mode,
   input wire [SELW-1:0] i_sec_reg,
   // Corrected access addresses
   output reg o_prd_valid,
   output reg [AW-1:0] o_prd_addr,
   output reg o_prd_wrapped,
   output reg o_pwr_valid,
   output reg [AW-1:0] o_pwr_addr,
   output reg o_pwr_wrapped,
   output reg o_sec_valid,
   output reg [AW-1:0] o_sec_addr,
   output reg o_sec_wrapped,
   // Pointer write-backs to the working register file
   output reg o_prd_wb,
   output reg [SELW-1:0] o_prd_wb_reg,
   output reg [AW-1:0] o_prd_wb_data,
   output reg o_pwr_wb,
   output reg [SELW-1:0] o_pwr_wb_reg,
   output reg [AW-1:0] o_pwr_wb_data,
   output reg o_sec_wb,
   output reg [SELW-1:0] o_sec_wb_reg,
   output reg [AW-1:0] o_sec_wb_data
);
   // ********************************************
   // Wrap units, one per address generator
   // ********************************************
   // Slot 0 is the primary read, slot 1 the primary write, slot 2 the secondary
   localparam NGEN = 3;
   wire [NGEN*AW-1:0] req_addr;
   wire [NGEN*AW-1:0] bnd_start;
   wire [NGEN*AW-1:0] bnd_end;
   wire [NGEN*2-1:0] req_mode;
   wire [NGEN-1:0] circ_on;
   wire [NGEN-1:0] dec_on;
   wire [NGEN*AW-1:0] fix_addr;
   wire [NGEN-1:0] fix_wrap;
   wire [NGEN-1:0] mod_wb;
   wire [AW-1:0] prd_fix;
   wire [AW-1:0] pwr_fix;
   wire [AW-1:0] sec_fix;
   wire prd_wr;
   wire pwr_wr;
   wire sec_wr;
   wire prd_mod;
   wire pwr_mod;
   wire sec_mod;
   wire pwr_circ;

   // Both primary slots share the primary bounds and direction
   assign req_addr = {i_sec_addr, i_pwr_addr, i_prd_addr};
   assign req_mode = {i_sec_mode, i_pwr_mode, i_prd_mode};
   assign bnd_start = {i_sec_start, i_pri_start, i_pri_start};
   assign bnd_end = {i_sec_end, i_pri_end, i_pri_end};
   assign dec_on = {i_sec_decrement, i_pri_decrement, i_pri_decrement};
   // Bit-reverse wins only on the primary write path; primary read stays circular
   assign pwr_circ = i_pri_circ_en & ~i_pri_bitrev_en;
   // Secondary space has its own enable and its own bounds
   assign circ_on = {i_sec_circ_en, pwr_circ, i_pri_circ_en};

   // Same check in every slot; any register index is accepted, no subset is special
   genvar g;
   generate
      for (g = 0; g < NGEN; g = g + 1)
      begin : g_slot
         mac_wrap #(.AW(AW)) u_wrap (
            .i_addr(req_addr[g*AW +: AW]),
            .i_start(bnd_start[g*AW +: AW]),
            .i_end(bnd_end[g*AW +: AW]),
            .i_enable(circ_on[g]),
            .i_decrement(dec_on[g]),
            .o_addr(fix_addr[g*AW +: AW]),
            .o_wrapped(fix_wrap[g])
         );
         // Offset and plain modes leave the base pointer untouched
         assign mod_wb[g] = (req_mode[2*g +: 2] == `MAC_MODE_PRE) |
            (req_mode[2*g +: 2] == `MAC_MODE_POST);
      end
   endgenerate

   // Split the slot vectors back out for the output registers
   assign prd_fix = fix_addr[AW-1:0];
   assign pwr_fix = fix_addr[2*AW-1:AW];
   assign sec_fix = fix_addr[3*AW-1:2*AW];
   assign {sec_wr, pwr_wr, prd_wr} = fix_wrap;
   assign {sec_mod, pwr_mod, prd_mod} = mod_wb;

   // ********************************************
   // Next output values
   // ********************************************
   reg next_prd_valid;
   reg [AW-1:0] next_prd_addr;
   reg next_prd_wrapped;
   reg next_pwr_valid;
   reg [AW-1:0] next_pwr_addr;
   reg next_pwr_wrapped;
   reg next_sec_valid;
   reg [AW-1:0] next_sec_addr;
   reg next_sec_wrapped;
   reg next_prd_wb;
   reg [SELW-1:0] next_prd_wb_reg;
   reg [AW-1:0] next_prd_wb_data;
   reg next_pwr_wb;
   reg [SELW-1:0] next_pwr_wb_reg;
   reg [AW-1:0] next_pwr_wb_data;
   reg next_sec_wb;
   reg [SELW-1:0] next_sec_wb_reg;
   reg [AW-1:0] next_sec_wb_data;

   // Flags are gated by valid so an idle slot never reports a wrap or a write-back
   always @*
   begin
      // Access addresses are always the corrected ones, offset mode too
      next_prd_valid = i_prd_valid;
      next_prd_addr = prd_fix;
      next_prd_wrapped = i_prd_valid & prd_wr;
      next_pwr_valid = i_pwr_valid;
      next_pwr_addr = pwr_fix;
      next_pwr_wrapped = i_pwr_valid & pwr_wr;
      next_sec_valid = i_sec_valid;
      next_sec_addr = sec_fix;
      next_sec_wrapped = i_sec_valid & sec_wr;
      // Pointer update only for pre- and post-modify
      next_prd_wb = i_prd_valid & prd_mod;
      next_prd_wb_reg = i_prd_reg;
      next_prd_wb_data = prd_fix;
      next_pwr_wb = i_pwr_valid & pwr_mod;
      next_pwr_wb_reg = i_pwr_reg;
      next_pwr_wb_data = pwr_fix;
      next_sec_wb = i_sec_valid & sec_mod;
      next_sec_wb_reg = i_sec_reg;
      next_sec_wb_data = sec_fix;
   end

   // ********************************************
   // Output registers
   // ********************************************
   // One cycle of latency keeps every output on a flip-flop
   always @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_prd_valid <= 1'b0;
         o_prd_addr <= `MAC_ADDR_RST;
         o_prd_wrapped <= 1'b0;
         o_pwr_valid <= 1'b0;
         o_pwr_addr <= `MAC_ADDR_RST;
         o_pwr_wrapped <= 1'b0;
         o_sec_valid <= 1'b0;
         o_sec_addr <= `MAC_ADDR_RST;
         o_sec_wrapped <= 1'b0;
         o_prd_wb <= 1'b0;
         o_prd_wb_reg <= {SELW{1'b0}};
         o_prd_wb_data <= `MAC_ADDR_RST;
         o_pwr_wb <= 1'b0;
         o_pwr_wb_reg <= {SELW{1'b0}};
         o_pwr_wb_data <= `MAC_ADDR_RST;
         o_sec_wb <= 1'b0;
         o_sec_wb_reg <= {SELW{1'b0}};
         o_sec_wb_data <= `MAC_ADDR_RST;
      end
      else
      begin
         // Addresses and data follow every cycle; only the flags depend on valid
         o_prd_valid <= next_prd_valid;
         o_prd_addr <= next_prd_addr;
         o_prd_wrapped <= next_prd_wrapped;
         o_pwr_valid <= next_pwr_valid;
         o_pwr_addr <= next_pwr_addr;
         o_pwr_wrapped <= next_pwr_wrapped;
         o_sec_valid <= next_sec_valid;
         o_sec_addr <= next_sec_addr;
         o_sec_wrapped <= next_sec_wrapped;
         // Write-back strobes stay high for as many cycles as a pre- or post-modify request is valid
         o_prd_wb <= next_prd_wb;
         o_prd_wb_reg <= next_prd_wb_reg;
         o_prd_wb_data <= next_prd_wb_data;
         o_pwr_wb <= next_pwr_wb;
         o_pwr_wb_reg <= next_pwr_wb_reg;
         o_pwr_wb_data <= next_pwr_wb_data;
         o_sec_wb <= next_sec_wb;
         o_sec_wb_reg <= next_sec_wb_reg;
         o_sec_wb_data <= next_sec_wb_data;
      end
   end
endmodule // mac_top
`default_nettype wire

// [hw/mac_wrap.v]
// One circular-buffer boundary check and wrap unit
`timescale 1ns/10ps
`default_nettype none
module mac_wrap #(
   parameter AW = 16
) (
   input wire [AW-1:0] i_addr,
   input wire [AW-1:0] i_start,
   input wire [AW-1:0] i_end,
   input wire i_enable,
   input wire i_decrement,
   output wire [AW-1:0] o_addr,
   output wire o_wrapped
);
   // Buffer length is end minus start plus one
   wire [AW-1:0] len;
   wire over_hi;
   wire under_lo;
   assign len = i_end - i_start + {{(AW-1){1'b0}}, 1'b1};
   // Magnitude tests catch a step that jumps past the boundary
   assign over_hi = (i_addr > i_end);
   assign under_lo = (i_addr < i_start);
   assign o_wrapped = i_enable & (i_decrement ? under_lo : over_hi);
   // Subtract length going up, add it going down
   assign o_addr = !o_wrapped ? i_addr :
      (i_decrement ? i_addr + len : i_addr - len);
endmodule // mac_wrap
`default_nettype wire

// [tb/mac_chk.sv]
// Checker for circular-buffer correction on the primary paths
`timescale 1ns/10ps
`default_nettype none
module mac_chk (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_pri_circ_en,
   input wire logic i_pri_decrement,
   input wire logic i_pri_bitrev_en,
   input wire logic i_prd_valid,
   input wire logic i_pwr_valid,
   input wire logic o_prd_wrapped,
   input wire logic o_prd_wb,
   input wire logic o_pwr_wrapped,
   input wire logic [15:0] i_pri_start,
   input wire logic [15:0] i_pri_end,
   input wire logic [15:0] i_prd_addr,
   input wire logic [15:0] o_prd_addr,
   input wire logic [15:0] o_prd_wb_data,
   input wire logic [1:0] i_prd_mode,
   input wire logic [3:0] i_prd_reg,
   input wire logic [3:0] o_prd_wb_reg
);
   // Wrap targets one buffer length away, kept as nets so $past sees a signal
   wire [15:0] up = i_prd_addr - i_pri_end + i_pri_start - 16'h1;
   wire [15:0] dn = i_prd_addr + i_pri_end - i_pri_start + 16'h1;
   wire go = i_prd_valid && i_pri_circ_en;
   wire inb = i_prd_addr >= i_pri_start && i_prd_addr <= i_pri_end;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   a_up_wrap: assert property (go && !i_pri_decrement && i_prd_addr > i_pri_end
      |=> o_prd_wrapped && o_prd_addr == $past(up)) else $error("up wrap");
   a_dn_wrap: assert property (go && i_pri_decrement && i_prd_addr < i_pri_start
      |=> o_prd_wrapped && o_prd_addr == $past(dn)) else $error("down wrap");
   a_inside_kept: assert property (go && inb
      |=> !o_prd_wrapped && o_prd_addr == $past(i_prd_addr)) else $error("inside");
   a_circ_off: assert property (i_prd_valid && !i_pri_circ_en
      |=> !o_prd_wrapped && o_prd_addr == $past(i_prd_addr)) else $error("off");
   a_mod_wb: assert property (i_prd_valid && i_prd_mode inside {2'h1, 2'h2}
      |=> o_prd_wb && o_prd_wb_data == o_prd_addr && o_prd_wb_reg == $past(i_prd_reg))
      else $error("writeback");
   a_offs_keep: assert property (i_prd_valid && i_prd_mode == 2'h3 |=> !o_prd_wb)
      else $error("offset wb");
   a_plain_nowb: assert property (i_prd_valid && i_prd_mode == 2'h0 |=> !o_prd_wb)
      else $error("plain wb");
   a_brev_prio: assert property (i_pwr_valid && i_pri_bitrev_en |=> !o_pwr_wrapped)
      else $error("bitrev");
endmodule // mac_chk
bind mac_top mac_chk chk_u (
   .i_core_clk(i_core_clk),
   .i_nrst(i_nrst),
   .i_pri_circ_en(i_pri_circ_en),
   .i_pri_decrement(i_pri_decrement),
   .i_pri_bitrev_en(i_pri_bitrev_en),
   .i_prd_valid(i_prd_valid),
   .i_pwr_valid(i_pwr_valid),
   .o_prd_wrapped(o_prd_wrapped),
   .o_prd_wb(o_prd_wb),
   .o_pwr_wrapped(o_pwr_wrapped),
   .i_pri_start(i_pri_start),
   .i_pri_end(i_pri_end),
   .i_prd_addr(i_prd_addr),
   .o_prd_addr(o_prd_addr),
   .o_prd_wb_data(o_prd_wb_data),
   .i_prd_mode(i_prd_mode),
   .i_prd_reg(i_prd_reg),
   .o_prd_wb_reg(o_prd_wb_reg)
);
`default_nettype wire

// [tb/tb_top.sv]
// Testbench for circular-buffer address correction
`timescale 1ns/10ps
`default_nettype none
`include "mac_defs.vh"
module tb_top;
   logic i_core_clk, i_nrst, i_pri_circ_en, i_sec_circ_en, i_pri_bitrev_en, i_pri_decrement;
   logic i_sec_decrement, i_prd_valid, i_pwr_valid, i_sec_valid, o_prd_valid, o_prd_wrapped;
   logic o_pwr_valid, o_pwr_wrapped, o_sec_valid, o_sec_wrapped, o_prd_wb, o_pwr_wb, o_sec_wb;
   logic [15:0] i_pri_start, i_pri_end, i_sec_start, i_sec_end, i_prd_addr, i_pwr_addr;
   logic [15:0] i_sec_addr, o_prd_addr, o_pwr_addr, o_sec_addr;
   logic [15:0] o_prd_wb_data, o_pwr_wb_data, o_sec_wb_data;
   logic [1:0] i_prd_mode, i_pwr_mode, i_sec_mode;
   logic [3:0] i_prd_reg, i_pwr_reg, i_sec_reg, o_prd_wb_reg, o_pwr_wb_reg, o_sec_wb_reg;
   logic [3:0] r = 4'h0;
   int error_cnt = 0;
   int num_checks = 0;
   mac_top dut_u (.*);
   initial
   begin
      i_core_clk = 0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   task chk(input logic [15:0] got, exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Same request on all three generators; valid drops a cycle so no double assignment
   task acc(input logic [15:0] a, ea, input logic [1:0] m, input logic w);
      logic wb;
      wb = m == 2'h1 || m == 2'h2;
      {i_prd_valid, i_pwr_valid, i_sec_valid} <= 3'h7;
      {i_prd_addr, i_pwr_addr, i_sec_addr} <= {3{a}};
      {i_prd_mode, i_pwr_mode, i_sec_mode} <= {3{m}};
      {i_prd_reg, i_pwr_reg, i_sec_reg} <= {3{r}};
      @(posedge i_core_clk);
      {i_prd_valid, i_pwr_valid, i_sec_valid} <= 3'h0;
      @(negedge i_core_clk);
      chk({o_prd_valid, o_pwr_valid, o_sec_valid}, 16'h7);
      chk({o_prd_addr}, ea);
      chk({o_sec_addr}, ea);
      chk({o_prd_wrapped, o_sec_wrapped}, {2{w}});
      chk({o_pwr_wrapped}, w & ~i_pri_bitrev_en);
      chk({o_pwr_addr}, i_pri_bitrev_en ? a : ea);
      chk({o_prd_wb, o_pwr_wb, o_sec_wb}, {3{wb}});
      chk({o_prd_wb_reg, o_pwr_wb_reg, o_sec_wb_reg}, {3{r}});
      if (wb) chk({o_prd_wb_data}, ea);
      if (wb) chk({o_sec_wb_data}, ea);
      if (wb) chk({o_pwr_wb_data}, i_pri_bitrev_en ? a : ea);
      r = r + 4'h1;
      // Valid, flags and write-backs stand for one cycle only
      @(negedge i_core_clk);
      chk({o_prd_valid, o_pwr_valid, o_sec_valid, o_prd_wb, o_pwr_wb, o_sec_wb}, 16'h0);
      chk({o_prd_wrapped, o_pwr_wrapped, o_sec_wrapped}, 16'h0);
      @(posedge i_core_clk);
   endtask
   task t_up;
      acc(16'h1100, 16'h1000, 2'h2, 1);
      acc(16'h1105, 16'h1005, 2'h1, 1);
      acc(16'h10ff, 16'h10ff, 2'h2, 0);
      acc(16'h1102, 16'h1002, 2'h3, 1);
      acc(16'h1101, 16'h1001, 2'h0, 1);
   endtask
   task t_dn;
      {i_pri_decrement, i_sec_decrement} <= 2'h3;
      acc(16'h0fff, 16'h10ff, 2'h2, 1);
      acc(16'h0ffa, 16'h10fa, 2'h1, 1);
      acc(16'h1000, 16'h1000, 2'h1, 0);
      {i_pri_decrement, i_sec_decrement} <= 2'h0;
   endtask
   // Bit-reverse then circular off: read path must keep wrapping only in the first
   task t_mix;
      i_pri_bitrev_en <= 1;
      acc(16'h1100, 16'h1000, 2'h2, 1);
      {i_pri_bitrev_en, i_pri_circ_en, i_sec_circ_en} <= 3'h0;
      acc(16'h1100, 16'h1100, 2'h2, 0);
      {i_pri_circ_en, i_sec_circ_en} <= 2'h3;
   endtask
   // Mid-run reset clears every output even while requests are held up
   task t_rst;
      i_nrst <= 0;
      {i_prd_valid, i_pwr_valid, i_sec_valid} <= 3'h7;
      @(negedge i_core_clk);
      chk({o_prd_valid, o_pwr_valid, o_sec_valid, o_prd_wrapped, o_pwr_wrapped}, 16'h0);
      chk({o_sec_wrapped, o_prd_wb, o_pwr_wb, o_sec_wb}, 16'h0);
      chk({o_prd_wb_reg, o_pwr_wb_reg, o_sec_wb_reg}, 16'h0);
      chk(o_prd_addr | o_pwr_addr | o_sec_addr, `MAC_ADDR_RST);
      chk(o_prd_wb_data | o_pwr_wb_data | o_sec_wb_data, `MAC_ADDR_RST);
      @(posedge i_core_clk);
      {i_prd_valid, i_pwr_valid, i_sec_valid} <= 3'h0;
      i_nrst <= 1;
      @(posedge i_core_clk);
   endtask
   task t_regs;
      for (int i = 0; i < 8; i++)
         acc(16'h1100 + 16'(i), 16'h1000 + 16'(i), 2'h1, 1);
   endtask
   task final_report;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      {i_nrst, i_prd_valid, i_pwr_valid, i_sec_valid, i_pri_bitrev_en} = 5'h0;
      {i_pri_circ_en, i_sec_circ_en, i_pri_decrement, i_sec_decrement} = 4'hc;
      {i_pri_start, i_sec_start, i_pri_end, i_sec_end} = {32'h10001000, 32'h10ff10ff};
      {i_prd_addr, i_pwr_addr, i_sec_addr, i_prd_mode, i_pwr_mode, i_sec_mode} = 54'h0;
      {i_prd_reg, i_pwr_reg, i_sec_reg} = 12'h0;
      repeat (10) @(posedge i_core_clk);
      i_nrst <= 1;
      t_up;
      t_dn;
      t_mix;
      t_rst;
      t_regs;
      final_report;
   end
   // About 70 cycles of work; a hang stops well after that
   initial
   begin
      #2000;
      error_cnt++;
      final_report;
   end
endmodule // tb_top
`default_nettype wire
